//--- ccd_pkg.sv
// Functional notes
// - Watchdog postscale code n gives ratio 1:2^n
// - Postscale codes above 10100 act as 10100
// - Output divisor codes give 1..64, 111 gives 256
// - USB PLL bypass bit set disables PLL
// - USB input divider codes give 1,2,3,4,5,6,10,12
// - Multiplier codes give 15..21, 111 gives 24
// - USB fields exist only on USB variants
package ccd_pkg;

	// Register byte offsets
	localparam logic [11:0] OFS_CFG_WORD = 12'h000;
	localparam logic [11:0] OFS_SYS_PLL  = 12'h004;
	localparam logic [11:0] OFS_USB_PLL  = 12'h008;
	localparam logic [11:0] OFS_WDOG     = 12'h00C;
	localparam logic [11:0] OFS_CTRL     = 12'h010;
	localparam logic [11:0] OFS_STATUS   = 12'h014;

	// Configuration word field positions
	localparam int ODIV_LSB     = 16;
	localparam int USB_BYP_BIT  = 15;
	localparam int USB_IDIV_LSB = 8;
	localparam int MULT_LSB     = 4;
	localparam logic [31:0] RESV_MASK = 32'hFFF8_7888;
	localparam logic [31:0] USB_MASK  = 32'h0000_8700;

	// Decoded register field positions
	localparam int SYS_ODIV_LSB = 16;
	localparam int USB_DIV_LSB  = 8;
	localparam int CTRL_APPLY   = 0;
	localparam int STAT_LOADED  = 0;
	localparam int STAT_RESV    = 1;

	// Decode constants
	localparam logic [4:0] WDOG_MAX_CODE = 5'h14;
	localparam logic [4:0] MULT_BASE     = 5'h0F;
	localparam logic [4:0] MULT_TOP      = 5'h18;
	localparam logic [8:0] ODIV_TOP      = 9'h100;

	// Reset values
	localparam logic        APPLY_RST = 1'b1;
	localparam logic [31:0] WORD_RST  = 32'h0000_0000;

	typedef enum logic [1:0] {CAP_SYNC0, CAP_SYNC1, CAP_LOAD, CAP_HOLD} ccd_cap_t;

	typedef struct packed {
		logic [31:0] word_s1;
		logic [31:0] word_s2;
		logic [4:0]  wsel_s1;
		logic [4:0]  wsel_s2;
		ccd_cap_t    cap;
		logic [31:0] word;
		logic [4:0]  wsel;
		logic [4:0]  mult;
		logic [8:0]  odiv;
		logic        byp;
		logic [3:0]  idiv;
		logic [4:0]  shift;
		logic        valid;
		logic        apply_en;
		logic        resv_err;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} ccd_state_t;

endpackage : ccd_pkg

//--- ccd_decoder.sv
`timescale 1ns/1ps
module ccd_decoder
#(
	parameter bit USB_PRESENT = 1'b1
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [31:0] clock_pll_config_word,
	input  wire logic [4:0]  wdog_postscale_sel,
	output logic [4:0]       sys_pll_mult,
	output logic [8:0]       sys_pll_out_div,
	output logic             usb_pll_bypass,
	output logic [3:0]       usb_pll_in_div,
	output logic [4:0]       wdog_postscale_shift,
	output logic             cfg_valid
);
	import ccd_pkg::*;

	ccd_state_t st_reg;
	ccd_state_t st_next;

	function automatic logic [4:0] wdog_fn(input logic [4:0] code);
		if (code > WDOG_MAX_CODE)
			return WDOG_MAX_CODE;
		return code;
	endfunction : wdog_fn

	function automatic logic [8:0] odiv_fn(input logic [2:0] code);
		if (code == 3'h7)
			return ODIV_TOP;
		return 9'(9'h001 << code);
	endfunction : odiv_fn

	function automatic logic [3:0] idiv_fn(input logic [2:0] code);
		unique case (code)
			3'h6:    return 4'hA;
			3'h7:    return 4'hC;
			default: return 4'({1'b0, code} + 4'h1);
		endcase
	endfunction : idiv_fn

	function automatic logic [4:0] mult_fn(input logic [2:0] code);
		if (code == 3'h7)
			return MULT_TOP;
		return 5'(MULT_BASE + {2'b00, code});
	endfunction : mult_fn

	logic        apb_done;
	logic        apb_hit;
	logic [31:0] rd_mux;
	logic [31:0] word_vis;

	always_comb
	begin
		st_next = st_reg;
		// Two stages before anything reads the pins
		st_next.word_s1 = clock_pll_config_word;
		st_next.word_s2 = st_reg.word_s1;
		st_next.wsel_s1 = wdog_postscale_sel;
		st_next.wsel_s2 = st_reg.wsel_s1;

		unique case (st_reg.cap)
			CAP_SYNC0:
				st_next.cap = CAP_SYNC1;
			CAP_SYNC1:
				st_next.cap = CAP_LOAD;
			CAP_LOAD:
			begin
				// One capture only; values stay frozen until the next reset
				st_next.cap   = CAP_HOLD;
				st_next.word  = st_reg.word_s2;
				st_next.wsel  = st_reg.wsel_s2;
				st_next.mult  = mult_fn(st_reg.word_s2[MULT_LSB +: 3]);
				st_next.odiv  = odiv_fn(st_reg.word_s2[ODIV_LSB +: 3]);
				st_next.shift = wdog_fn(st_reg.wsel_s2);
				if (USB_PRESENT)
				begin
					st_next.byp  = st_reg.word_s2[USB_BYP_BIT];
					st_next.idiv = idiv_fn(st_reg.word_s2[USB_IDIV_LSB +: 3]);
				end
				else
				begin
					// Absent USB logic behaves as a bypassed PLL
					st_next.byp  = 1'b1;
					st_next.idiv = 4'h1;
				end
				if ((st_reg.word_s2 & RESV_MASK) != RESV_MASK)
					st_next.resv_err = 1'b1;
			end
			CAP_HOLD:
				st_next.cap = CAP_HOLD;
		endcase

		st_next.valid = (st_reg.cap == CAP_HOLD) && st_reg.apply_en;

		word_vis = USB_PRESENT ? st_reg.word : (st_reg.word & ~USB_MASK);
		apb_hit  = (paddr[11:5] == 7'h00) && (paddr[4:2] <= 3'h5);
		apb_done = psel && penable && st_reg.pready;

		rd_mux = 32'h0000_0000;
		unique case ({paddr[11:2], 2'b00})
			OFS_CFG_WORD:
				rd_mux = word_vis;
			OFS_SYS_PLL:
			begin
				rd_mux[4:0] = st_reg.mult;
				rd_mux[SYS_ODIV_LSB +: 9] = st_reg.odiv;
			end
			OFS_USB_PLL:
			begin
				rd_mux[0] = st_reg.byp;
				rd_mux[USB_DIV_LSB +: 4] = st_reg.idiv;
			end
			OFS_WDOG:
				rd_mux[4:0] = st_reg.shift;
			OFS_CTRL:
				rd_mux[CTRL_APPLY] = st_reg.apply_en;
			OFS_STATUS:
			begin
				rd_mux[STAT_LOADED] = (st_reg.cap == CAP_HOLD);
				rd_mux[STAT_RESV]   = st_reg.resv_err;
			end
			default:
				rd_mux = 32'h0000_0000;
		endcase

		// One wait state so that every output comes from a flip-flop
		st_next.pready  = psel && penable && !st_reg.pready;
		st_next.pslverr = psel && penable && !st_reg.pready && !apb_hit;
		if (psel && penable && !st_reg.pready && !pwrite)
			st_next.prdata = rd_mux;

		if (apb_done && pwrite && apb_hit)
		begin
			if ({paddr[11:2], 2'b00} == OFS_CTRL)
				st_next.apply_en = pwdata[CTRL_APPLY];
			// Capture sets in the same cycle win over a clear
			if ({paddr[11:2], 2'b00} == OFS_STATUS && pwdata[STAT_RESV] && st_reg.cap != CAP_LOAD)
				st_next.resv_err = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg          <= '0;
			st_reg.cap      <= CAP_SYNC0;
			st_reg.word     <= WORD_RST;
			st_reg.odiv     <= 9'h001;
			st_reg.idiv     <= 4'h1;
			st_reg.mult     <= MULT_BASE;
			st_reg.byp      <= 1'b1;
			st_reg.apply_en <= APPLY_RST;
		end
		else
			st_reg <= st_next;
	end

	assign pready               = st_reg.pready;
	assign prdata               = st_reg.prdata;
	assign pslverr              = st_reg.pslverr;
	assign sys_pll_mult         = st_reg.mult;
	assign sys_pll_out_div      = st_reg.odiv;
	assign usb_pll_bypass       = st_reg.byp;
	assign usb_pll_in_div       = st_reg.idiv;
	assign wdog_postscale_shift = st_reg.shift;
	assign cfg_valid            = st_reg.valid;

	logic        cap_hold;
	logic        cap_load;
	logic        acc_first;
	logic        acc_read;
	logic        acc_wr_done;
	logic        resv_viol;
	logic [11:0] acc_ofs;
	assign cap_hold    = (st_reg.cap == CAP_HOLD);
	assign cap_load    = (st_reg.cap == CAP_LOAD);
	assign acc_first   = psel && penable && !pready;
	assign acc_read    = acc_first && !pwrite;
	assign acc_wr_done = psel && penable && pready && pwrite;
	assign resv_viol   = (st_reg.word_s2 & RESV_MASK) != RESV_MASK;
	assign acc_ofs     = {paddr[11:2], 2'b00};

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Capture checks look one edge after the load state, at the word it took
	wdog_ratio_a: assert property (cap_load && st_reg.wsel_s2 <= 5'h14
		|=> wdog_postscale_shift == $past(st_reg.wsel_s2))
		else $error("watchdog postscale code decoded wrong");
	wdog_sat_a: assert property (cap_load && st_reg.wsel_s2 > 5'h14
		|=> wdog_postscale_shift == 5'h14)
		else $error("watchdog postscale not saturated");
	out_div_a: assert property (cap_load && st_reg.word_s2[18:16] != 3'h7
		|=> sys_pll_out_div == 9'(9'h001 << $past(st_reg.word_s2[18:16])))
		else $error("output divisor decoded wrong");
	out_div_top_a: assert property (cap_load && st_reg.word_s2[18:16] == 3'h7
		|=> sys_pll_out_div == 9'h100)
		else $error("output divisor top code wrong");
	usb_bypass_a: assert property (cap_load && USB_PRESENT
		|=> usb_pll_bypass == $past(st_reg.word_s2[15]))
		else $error("usb bypass bit decoded wrong");
	usb_div_a: assert property (cap_load && USB_PRESENT && st_reg.word_s2[10:8] == 3'h6
		|=> usb_pll_in_div == 4'hA)
		else $error("usb input divider code 6 wrong");
	usb_div_top_a: assert property (cap_load && USB_PRESENT && st_reg.word_s2[10:8] == 3'h7
		|=> usb_pll_in_div == 4'hC)
		else $error("usb input divider code 7 wrong");
	usb_div_low_a: assert property (cap_load && USB_PRESENT && st_reg.word_s2[10:8] < 3'h6
		|=> usb_pll_in_div == {1'b0, $past(st_reg.word_s2[10:8])} + 4'h1)
		else $error("usb input divider low code wrong");
	pll_mult_a: assert property (cap_load && st_reg.word_s2[6:4] != 3'h7
		|=> sys_pll_mult == 5'h0F + {2'b00, $past(st_reg.word_s2[6:4])})
		else $error("pll multiplier decoded wrong");
	pll_mult_top_a: assert property (cap_load && st_reg.word_s2[6:4] == 3'h7
		|=> sys_pll_mult == 5'h18)
		else $error("pll multiplier top code wrong");

	resv_check_a: assert property (cap_load && resv_viol
		|=> st_reg.resv_err)
		else $error("reserved bit violation not flagged");
	resv_keep_a: assert property (st_reg.resv_err && !(acc_wr_done && acc_ofs == OFS_STATUS && pwdata[STAT_RESV])
		|=> st_reg.resv_err)
		else $error("reserved bit flag lost without clear");
	resv_clean_a: assert property (cap_load && !resv_viol && !st_reg.resv_err
		|=> !st_reg.resv_err)
		else $error("reserved bit flag set on clean word");
	no_usb_a: assert property (cap_hold && !USB_PRESENT
		|-> usb_pll_bypass && usb_pll_in_div == 4'h1)
		else $error("usb fields active on non usb variant");
	no_usb_word_a: assert property (acc_read && acc_ofs == OFS_CFG_WORD && !USB_PRESENT
		|=> (prdata & USB_MASK) == 32'h0000_0000)
		else $error("usb bits visible on non usb variant");

	held_vals_a: assert property (cap_hold
		|=> $stable(sys_pll_mult) && $stable(sys_pll_out_div) && $stable(usb_pll_in_div)
		&& $stable(wdog_postscale_shift) && $stable(usb_pll_bypass))
		else $error("decoded values changed after capture");
	load_time_a: assert property ($rose(presetn)
		|-> ##[0:3] cap_hold)
		else $error("capture not done three cycles after reset");
	valid_gate_a: assert property (cfg_valid
		|-> cap_hold)
		else $error("valid shown before capture");
	valid_apply_a: assert property (cap_hold && st_reg.apply_en
		|=> cfg_valid)
		else $error("valid missing after capture");
	valid_off_a: assert property (!st_reg.apply_en
		|=> !cfg_valid)
		else $error("valid shown with apply cleared");
	ro_write_a: assert property (cap_hold && acc_wr_done && acc_ofs == OFS_SYS_PLL
		|=> $stable(sys_pll_mult) && $stable(sys_pll_out_div))
		else $error("write changed read only values");

	// Bus checks: one wait state, error only in the answer cycle, read data checked in that cycle
	apb_answer_a: assert property (acc_first
		|=> pready)
		else $error("apb access not answered in one cycle");
	apb_pulse_a: assert property (pready
		|=> !pready)
		else $error("apb ready longer than one cycle");
	apb_idle_a: assert property (!psel
		|=> !pready && !pslverr)
		else $error("apb answer without select");
	apb_err_a: assert property (acc_first && !apb_hit
		|=> pready && pslverr)
		else $error("unmapped access without error");
	apb_ok_a: assert property (acc_first && apb_hit
		|=> !pslverr)
		else $error("mapped access flagged as error");
	rd_unmapped_a: assert property (acc_read && !apb_hit
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read data not zero");
	rd_sys_a: assert property (acc_read && acc_ofs == OFS_SYS_PLL
		|=> prdata == {7'h00, $past(sys_pll_out_div), 11'h000, $past(sys_pll_mult)})
		else $error("system pll register read wrong");
	rd_usb_a: assert property (acc_read && acc_ofs == OFS_USB_PLL
		|=> prdata == {20'h00000, $past(usb_pll_in_div), 7'h00, $past(usb_pll_bypass)})
		else $error("usb pll register read wrong");
	rd_wdog_a: assert property (acc_read && acc_ofs == OFS_WDOG
		|=> prdata == {27'h0000000, $past(wdog_postscale_shift)})
		else $error("watchdog register read wrong");
	ctrl_write_a: assert property (acc_wr_done && acc_ofs == OFS_CTRL
		|=> st_reg.apply_en == $past(pwdata[CTRL_APPLY]))
		else $error("control write not applied");

	hold_c: cover property (cap_hold && cfg_valid);
	read_c: cover property (psel && penable && pready && !pwrite && !pslverr);
	ctrl_wr_c: cover property (psel && penable && pready && pwrite && paddr == OFS_CTRL);
	unmapped_c: cover property (pready && pslverr);
	// Decoded values kept while the apply gate is off
	apply_off_c: cover property (cap_hold && !st_reg.apply_en);

endmodule : ccd_decoder

//--- tb_config_word_clock_decoder.sv
`timescale 1ns/1ps
module tb_config_word_clock_decoder;
	import ccd_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        usb_pll_bypass, cfg_valid, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, clock_pll_config_word, rd, word, seed;
	logic [4:0]  wdog_postscale_sel, sys_pll_mult, wdog_postscale_shift, wsel;
	logic [8:0]  sys_pll_out_div;
	logic [3:0]  usb_pll_in_div;
	int          n_mismatch, samples_checked, em, eo, ei, es;
	int          itab[8] = '{1, 2, 3, 4, 5, 6, 10, 12};

	ccd_decoder u_ccd_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.clock_pll_config_word(clock_pll_config_word), .wdog_postscale_sel(wdog_postscale_sel),
		.sys_pll_mult(sys_pll_mult), .sys_pll_out_div(sys_pll_out_div), .usb_pll_bypass(usb_pll_bypass),
		.usb_pll_in_div(usb_pll_in_div), .wdog_postscale_shift(wdog_postscale_shift), .cfg_valid(cfg_valid));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input bit ok, input string m);
		samples_checked++;
		if (!ok)
		begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	// Request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			chk(0, "bus timeout");
			test_done();
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic round(input int i);
		seed = xs(seed);
		word = (i % 2) ? (seed | 32'hFFF8_7888) : seed;
		wsel = 5'(i);
		@(posedge pclk);
		presetn <= 1'b0;
		clock_pll_config_word <= word;
		wdog_postscale_sel <= wsel;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		// Inputs move after capture; outputs must not follow
		clock_pll_config_word <= ~word;
		wdog_postscale_sel <= ~wsel;
		repeat (3) @(posedge pclk);
		em = (word[6:4] == 3'h7) ? 24 : 15 + word[6:4];
		eo = (word[18:16] == 3'h7) ? 256 : 1 << word[18:16];
		ei = itab[word[10:8]];
		es = (wsel > 5'h14) ? 20 : wsel;
		chk(sys_pll_mult === 5'(em), "mult");
		chk(sys_pll_out_div === 9'(eo), "out div");
		chk(usb_pll_in_div === 4'(ei), "usb div");
		chk(usb_pll_bypass === word[15], "bypass");
		chk(wdog_postscale_shift === 5'(es), "shift");
		chk(cfg_valid === 1'b1, "valid");
		apb(1'b0, OFS_SYS_PLL, 32'h0);
		chk(rd === ((32'(eo) << 16) | 32'(em)), "sys reg");
		apb(1'b0, OFS_USB_PLL, 32'h0);
		chk(rd === ((32'(ei) << 8) | 32'(word[15])), "usb reg");
		apb(1'b0, OFS_WDOG, 32'h0);
		chk(rd === 32'(es), "wdog reg");
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd === {30'h0, (word & 32'hFFF8_7888) != 32'hFFF8_7888, 1'b1}, "status");
		apb(1'b1, OFS_STATUS, 32'h2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd === 32'h1, "status clear");
		apb(1'b0, OFS_CFG_WORD, 32'h0);
		chk(rd === word, "word");
		$display("round %0d done", i);
	endtask : round

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clock_pll_config_word = 32'hFFFF_FFFF;
		wdog_postscale_sel = 5'h00;
		seed = 32'h0000_E0BD;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 32; i++)
			round(i);
		apb(1'b1, OFS_SYS_PLL, 32'hFFFF_FFFF);
		apb(1'b0, OFS_SYS_PLL, 32'h0);
		chk(rd === ((32'(eo) << 16) | 32'(em)), "ro write");
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		chk(cfg_valid === 1'b0 && sys_pll_mult === 5'(em), "apply off");
		apb(1'b0, 12'h018, 32'h0);
		chk(e === 1'b1 && rd === 32'h0, "unmapped");
		apb(1'b0, 12'h020, 32'h0);
		chk(e === 1'b1, "unmapped high");
		$display("bus tests done");
		test_done();
	end
endmodule : tb_config_word_clock_decoder
